// ==== core/cfx_exec.sv ====
// Executor for calls, sign extensions and flag/task-switched clears.
// Assumes operands held stable from issue until done; memory, stack and
// descriptor lookups are done by the core around this block.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RL1: 16-bit relative call clears upper instruction pointer half.
// RL2: Relative target is next instruction address plus signed displacement.
// RL3: Near call pushes the next sequential offset before jumping.
// RL4: Near indirect target is operand value, 16 or 32 bits by size.
// RL5: Far pointer is 4 or 6 bytes, immediate or from memory.
// RL6: Real/V86 far call loads 16-bit selector and 16/32-bit offset.
// RL7: Real/V86 far call pushes selector and instruction pointer.
// RL8: Protected far call picks transfer kind from access-rights byte.
// RL9: Stack-based memory operand uses stack pointer from before call.
// RL10: Task switch loads all flags; other calls leave flags alone.
// RL11: Near direct: GP 13 past code limit, SS 12 on stack overrun.
// RL12: Near indirect: GP 13 bad address or limit, SS 12 bad stack.
// RL13: Near calls: page fault 14, alignment 17 at privilege 3.
// RL14: Real/V86: GP 13 if operand leaves 0 to 0FFFFh.
// RL15: Byte to word, 3 clocks, fills high byte with sign, no flags.
// RL16: Dword to qword, 3 clocks, fills data register with sign.
// RL17: Clear carry, 2 clocks, touches nothing else.
// RL18: Clear direction, 2 clocks, string ops then increment.
// RL19: Clear interrupt enable, 5 clocks, only if privilege allows.
// RL20: Protected/V86 clear interrupt with low privilege raises GP 13.
// RL21: Clear task-switched, 7 clocks, privilege level 0 only.
// RL22: Every task switch sets the task-switched bit.
// RL23: Escape traps on task-switched; wait needs monitor bit too.
// RL24: Clear task-switched off level 0 in protected/V86 raises GP 13.
module cfx_exec #(
  parameter int CALL_CLOCKS = 3
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic issue_in,
  input wire cfx_pkg::cfx_op_type op_in,
  input wire logic osz32_in,
  input wire cfx_pkg::cfx_mode_type mode_in,
  input wire logic [1:0] current_privilege_level_in,
  input wire logic [31:0] next_ip_in,
  input wire logic [31:0] disp_in,
  input wire logic [31:0] ind_target_in,
  input wire logic ind_mem_in,
  input wire logic [15:0] far_sel_in,
  input wire logic [31:0] far_off_in,
  input wire logic [7:0] access_rights_byte_in,
  input wire logic [15:0] cur_cs_in,
  input wire logic [31:0] cs_limit_in,
  input wire logic [31:0] stack_pointer_in,
  input wire logic sp_base_in,
  input wire logic [31:0] ea_base_in,
  input wire logic [31:0] ea_disp_in,
  input wire logic ea_bad_in,
  input wire logic stack_bad_in,
  input wire logic page_fault_in,
  input wire logic misaligned_in,
  input wire logic [31:0] task_flags_in,
  input wire logic [7:0] accum_low_byte_in,
  input wire logic [31:0] accum_dword_in,
  input wire logic esc_check_in,
  input wire logic wait_check_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic busy_out,
  output logic done_out,
  output logic fault_out,
  output logic [7:0] fault_vec_out,
  output logic ip_wr_out,
  output logic [31:0] instruction_pointer_out,
  output logic cs_wr_out,
  output logic [15:0] cs_out,
  output logic push_ip_out,
  output logic push_cs_out,
  output logic [31:0] ret_ip_out,
  output logic [15:0] ret_cs_out,
  output logic [31:0] mem_ea_out,
  output cfx_pkg::cfx_xfer_type xfer_out,
  output logic task_switch_out,
  output logic ah_wr_out,
  output logic [7:0] accum_high_byte_out,
  output logic edx_wr_out,
  output logic [31:0] data_dword_reg_out,
  output logic [31:0] flags_out,
  output logic task_switched_bit_out,
  output logic coproc_trap_out,
  output logic [31:0] reg_rdata_out
);
  import cfx_pkg::*;

  initial begin
    if (CALL_CLOCKS < 1 || CALL_CLOCKS > 15) begin
      $error("CALL_CLOCKS must lie in 1 to 15");
    end
  end

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} cfx_state_type;

  cfx_state_type state_q, state_d;
  cfx_op_type op_q, op_d;
  logic [3:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d, fault_q, fault_d;
  logic [7:0] vec_q, vec_d;
  logic ipw_q, ipw_d, csw_q, csw_d, pip_q, pip_d, pcs_q, pcs_d;
  logic [31:0] ip_q, ip_d, rip_q, rip_d, ea_q, ea_d;
  logic [15:0] cs_q, cs_d, rcs_q, rcs_d;
  cfx_xfer_type xfer_q, xfer_d;
  logic tsw_q, tsw_d, ahw_q, ahw_d, edw_q, edw_d;
  logic [7:0] ah_q, ah_d;
  logic [31:0] edx_q, edx_d, flags_q, flags_d, rd_q, rd_d;
  logic ts_q, ts_d, mp_q, mp_d, trap_q, trap_d;

  // Per-op quantities at the finishing cycle
  logic fin, prot, rv, cpl3, near_op, far_op, mem_op;
  logic [31:0] tgt, ip_word;
  logic [32:0] ea_end;
  logic [1:0] io_privilege_level, dpl;
  logic [3:0] clocks;

  ////////////////////////////////////////////////////////////////////////
  // Sequencing and call/extension results
  always_comb begin
    fin = (state_q == ST_RUN) && (cnt_q == 4'h0);
    prot = (mode_in == MODE_PROT);
    rv = !prot;
    cpl3 = (current_privilege_level_in == 2'h3);
    near_op = (op_q == OP_CALL_REL) || (op_q == OP_CALL_IND);
    far_op = (op_q == OP_CALL_FAR_DIR) || (op_q == OP_CALL_FAR_IND);
    mem_op = (op_q == OP_CALL_FAR_IND) || ((op_q == OP_CALL_IND) && ind_mem_in);
    io_privilege_level = flags_q[FLAG_IO_PRIVILEGE_LEVEL_LO +: 2];
    dpl = access_rights_byte_in[AR_DPL_LO +: 2];
    // Last byte of the memory operand for the range check
    ea_end = {1'b0, ea_q} + {30'h0, osz32_in, !osz32_in, 1'b1}
      + (op_q == OP_CALL_FAR_IND ? 33'h2 : 33'h0) - 33'h2; // see RL5
    ip_word = osz32_in ? next_ip_in : (next_ip_in & LOW_WORD_MASK);
    unique case (op_q)
      OP_CALL_REL: tgt = next_ip_in + disp_in; // see RL2
      OP_CALL_IND: tgt = ind_target_in; // see RL4
      default: tgt = far_off_in; // see RL6
    endcase
    if (!osz32_in) begin
      tgt = tgt & LOW_WORD_MASK; // see RL1
    end
    // Clocks of the op offered for issue
    unique case (op_in)
      OP_BYTE_TO_WORD: clocks = CLK_BYTE_TO_WORD;
      OP_DWORD_TO_QWORD: clocks = CLK_DWORD_TO_QWORD;
      OP_CLR_CARRY: clocks = CLK_CLR_CARRY;
      OP_CLR_DIR: clocks = CLK_CLR_DIR;
      OP_CLR_INT: clocks = CLK_CLR_INT;
      OP_CLR_TS: clocks = CLK_CLR_TS;
      default: clocks = CALL_CLOCKS[3:0];
    endcase

    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    fault_d = 1'b0;
    vec_d = vec_q;
    {ipw_d, csw_d, pip_d, pcs_d, tsw_d, ahw_d, edw_d} = 7'h00;
    ip_d = ip_q;
    cs_d = cs_q;
    rip_d = rip_q;
    rcs_d = rcs_q;
    ea_d = ea_q;
    xfer_d = xfer_q;
    ah_d = ah_q;
    edx_d = edx_q;
    unique case (state_q)
      ST_IDLE: begin
        if (issue_in) begin
          state_d = ST_RUN;
          busy_d = 1'b1;
          op_d = op_in;
          cnt_d = clocks - 4'h1;
          // Stack pointer sampled before any push of this call
          ea_d = (sp_base_in ? stack_pointer_in : ea_base_in)
            + ea_disp_in; // see RL9
        end
      end
      ST_RUN: begin
        cnt_d = cnt_q - 4'h1;
        if (fin) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase

    if (fin) begin
      if (near_op || far_op) begin
        // Fault checks, first hit wins
        if (rv && mem_op && ea_end > REAL_EA_MAX) begin
          fault_d = 1'b1; // see RL14
          vec_d = VEC_GEN_PROT;
        end else if (prot && op_q == OP_CALL_IND && ea_bad_in) begin
          fault_d = 1'b1; // see RL12
          vec_d = VEC_GEN_PROT;
        end else if (mode_in != MODE_REAL && page_fault_in) begin
          fault_d = 1'b1; // see RL13
          vec_d = VEC_PAGE;
        end else if (mode_in != MODE_REAL && cpl3 && misaligned_in) begin
          fault_d = 1'b1; // see RL13
          vec_d = VEC_ALIGN;
        end else if (prot && stack_bad_in) begin
          fault_d = 1'b1; // see RL11 RL12
          vec_d = VEC_STACK;
        end else if (prot && near_op && tgt > cs_limit_in) begin
          fault_d = 1'b1; // see RL11 RL12
          vec_d = VEC_GEN_PROT;
        end else if (prot && far_op && !access_rights_byte_in[AR_SEG]
            && access_rights_byte_in[3:0] != AR_TASK_GATE
            && access_rights_byte_in[3:0] != AR_TSS_AVAIL
            && access_rights_byte_in[3:0] != AR_CALL_GATE) begin
          fault_d = 1'b1;
          vec_d = VEC_GEN_PROT;
        end
        if (!fault_d) begin
          ipw_d = 1'b1;
          ip_d = tgt;
          rip_d = ip_word;
          rcs_d = cur_cs_in;
          xfer_d = XFER_NEAR;
          pip_d = 1'b1; // see RL3 RL7
          if (far_op) begin
            csw_d = 1'b1;
            cs_d = far_sel_in; // see RL6
            pcs_d = 1'b1; // see RL7
            if (prot) begin
              // Transfer kind from the descriptor type, see RL8
              if (access_rights_byte_in[AR_SEG]) begin
                xfer_d = XFER_FAR_SAME;
              end else if (access_rights_byte_in[3:0] == AR_CALL_GATE
                  && dpl < current_privilege_level_in) begin
                xfer_d = XFER_FAR_INTER;
              end else if (access_rights_byte_in[3:0] == AR_CALL_GATE) begin
                xfer_d = XFER_FAR_SAME;
              end else begin
                xfer_d = XFER_TASK;
                tsw_d = 1'b1;
                {pip_d, pcs_d} = 2'b00;
              end
            end
          end
        end
      end
      if (op_q == OP_BYTE_TO_WORD) begin
        ahw_d = 1'b1;
        ah_d = {8{accum_low_byte_in[7]}}; // see RL15
      end
      if (op_q == OP_DWORD_TO_QWORD) begin
        edw_d = 1'b1;
        edx_d = accum_dword_in[31] ? SIGN_FILL : 32'h0; // see RL16
      end
      if (op_q == OP_CLR_INT && current_privilege_level_in > io_privilege_level && rv == 1'b0
          || op_q == OP_CLR_INT && mode_in == MODE_V86
          && current_privilege_level_in > io_privilege_level) begin
        fault_d = 1'b1; // see RL20
        vec_d = VEC_GEN_PROT;
      end
      if (op_q == OP_CLR_TS && mode_in != MODE_REAL
          && current_privilege_level_in != 2'h0) begin
        fault_d = 1'b1; // see RL24
        vec_d = VEC_GEN_PROT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Architectural state and register port
  always_comb begin
    flags_d = flags_q;
    ts_d = ts_q;
    mp_d = mp_q;
    if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      ts_d = reg_wdata_in[CR0_TS];
      mp_d = reg_wdata_in[CR0_MP];
    end
    if (reg_wr_in && reg_addr_in == REG_FLAGS) begin
      flags_d = reg_wdata_in | FLAGS_RESET;
    end
    if (fin && !fault_d) begin
      unique case (op_q)
        OP_CLR_CARRY: flags_d[FLAG_CARRY] = 1'b0; // see RL17
        OP_CLR_DIR: flags_d[FLAG_DIR] = 1'b0; // see RL18
        OP_CLR_INT: flags_d[FLAG_INT_EN] = 1'b0; // see RL19
        OP_CLR_TS: ts_d = 1'b0; // see RL21
        default: flags_d = flags_d;
      endcase
    end
    // Task switch loads flags and sets the bit, winning over clears
    if (tsw_d) begin
      flags_d = task_flags_in | FLAGS_RESET; // see RL10
      ts_d = 1'b1; // see RL22
    end
    trap_d = ts_q && (esc_check_in || (wait_check_in && mp_q)); // see RL23
    rd_d = 32'h0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CTRL: rd_d = {28'h0, ts_q, 1'b0, mp_q, 1'b0};
        REG_FLAGS: rd_d = flags_q;
        REG_STATUS: rd_d = {19'h0, op_q, vec_q, busy_q};
        default: rd_d = 32'h0;
      endcase
    end
  end

  // Registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      cnt_q <= 4'h0;
      {busy_q, done_q, fault_q, ipw_q, csw_q, pip_q, pcs_q} <= 7'h00;
      {tsw_q, ahw_q, edw_q, ts_q, mp_q, trap_q} <= 6'h00;
      vec_q <= 8'h00;
      ip_q <= 32'h0;
      rip_q <= 32'h0;
      ea_q <= 32'h0;
      edx_q <= 32'h0;
      rd_q <= 32'h0;
      cs_q <= 16'h0;
      rcs_q <= 16'h0;
      ah_q <= 8'h00;
      xfer_q <= XFER_NEAR;
      flags_q <= FLAGS_RESET;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      {busy_q, done_q, fault_q, ipw_q, csw_q, pip_q, pcs_q} <=
        {busy_d, done_d, fault_d, ipw_d, csw_d, pip_d, pcs_d};
      {tsw_q, ahw_q, edw_q, ts_q, mp_q, trap_q} <=
        {tsw_d, ahw_d, edw_d, ts_d, mp_d, trap_d};
      vec_q <= vec_d;
      ip_q <= ip_d;
      rip_q <= rip_d;
      ea_q <= ea_d;
      edx_q <= edx_d;
      rd_q <= rd_d;
      cs_q <= cs_d;
      rcs_q <= rcs_d;
      ah_q <= ah_d;
      xfer_q <= xfer_d;
      flags_q <= flags_d;
    end
  end

  // Outputs straight from flops
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign fault_out = fault_q;
  assign fault_vec_out = vec_q;
  assign ip_wr_out = ipw_q;
  assign instruction_pointer_out = ip_q;
  assign cs_wr_out = csw_q;
  assign cs_out = cs_q;
  assign push_ip_out = pip_q;
  assign push_cs_out = pcs_q;
  assign ret_ip_out = rip_q;
  assign ret_cs_out = rcs_q;
  assign mem_ea_out = ea_q;
  assign xfer_out = xfer_q;
  assign task_switch_out = tsw_q;
  assign ah_wr_out = ahw_q;
  assign accum_high_byte_out = ah_q;
  assign edx_wr_out = edw_q;
  assign data_dword_reg_out = edx_q;
  assign flags_out = flags_q;
  assign task_switched_bit_out = ts_q;
  assign coproc_trap_out = trap_q;
  assign reg_rdata_out = rd_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rel16_upper;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ipw_d && op_q == OP_CALL_REL && !osz32_in
      |=> instruction_pointer_out[31:16] == 16'h0;
  endproperty
  a_rel16_upper: assert property (p_rel16_upper) // see RL1
    else $error("16-bit relative call left upper pointer bits set");

  property p_btw_clocks;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    issue_in && !busy_out && op_in == OP_BYTE_TO_WORD
      |-> ##1 !done_out [*3] ##1 done_out && ah_wr_out;
  endproperty
  a_btw_clocks: assert property (p_btw_clocks) // see RL15
    else $error("byte to word did not finish in three clocks");

  property p_sign_fill;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    edx_wr_out |-> data_dword_reg_out == {32{$past(accum_dword_in[31])}};
  endproperty
  a_sign_fill: assert property (p_sign_fill) // see RL16
    else $error("data register not filled with accumulator sign");

  property p_clr_carry;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    done_out && op_q == OP_CLR_CARRY && !$past(reg_wr_in)
      |-> !flags_out[FLAG_CARRY]
      && flags_out[31:1] == $past(flags_out[31:1]);
  endproperty
  a_clr_carry: assert property (p_clr_carry) // see RL17
    else $error("clear carry touched other flags or left carry set");

  property p_cli_fault;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    fin && op_q == OP_CLR_INT && mode_in != MODE_REAL
      && current_privilege_level_in > io_privilege_level
      |=> fault_out && fault_vec_out == VEC_GEN_PROT;
  endproperty
  a_cli_fault: assert property (p_cli_fault) // see RL20
    else $error("unprivileged interrupt clear did not fault");

  property p_clear_task_switched_insn_fault;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    fin && op_q == OP_CLR_TS && mode_in != MODE_REAL
      && current_privilege_level_in != 2'h0 && !reg_wr_in
      |=> fault_out && task_switched_bit_out == $past(task_switched_bit_out);
  endproperty
  a_clear_task_switched_insn_fault: assert property (p_clear_task_switched_insn_fault) // see RL24
    else $error("task-switched clear off level 0 did not fault");

  property p_ts_set;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    task_switch_out |-> task_switched_bit_out && xfer_out == XFER_TASK;
  endproperty
  a_ts_set: assert property (p_ts_set) // see RL22
    else $error("task switch did not set task-switched bit");

  property p_trap;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    task_switched_bit_out && esc_check_in ##1 1'b1 |-> coproc_trap_out;
  endproperty
  a_trap: assert property (p_trap) // see RL23
    else $error("escape not trapped with task-switched set");

  property p_call_flags;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    done_out && !task_switch_out && (near_op || far_op) && !$past(reg_wr_in)
      |-> flags_out == $past(flags_out);
  endproperty
  a_call_flags: assert property (p_call_flags) // see RL10
    else $error("call without task switch changed flags");
endmodule : cfx_exec

`default_nettype wire

// ==== pkg/cfx_pkg.sv ====
// Constants, encodings and timing counts for the call and flag executor.
// Assumes a 32-bit core datapath and a 25 MHz core clock.
package cfx_pkg;
  // Instruction classes handed over by the decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CALL_REL = 4'h1, OP_CALL_IND = 4'h2,
    OP_CALL_FAR_DIR = 4'h3, OP_CALL_FAR_IND = 4'h4, OP_BYTE_TO_WORD = 4'h5,
    OP_DWORD_TO_QWORD = 4'h6, OP_CLR_CARRY = 4'h7, OP_CLR_DIR = 4'h8,
    OP_CLR_INT = 4'h9, OP_CLR_TS = 4'ha
  } cfx_op_type;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_REAL = 2'h0, MODE_PROT = 2'h1, MODE_V86 = 2'h2
  } cfx_mode_type;
  // Kind of control transfer of a call
  typedef enum logic [1:0] {
    XFER_NEAR = 2'h0, XFER_FAR_SAME = 2'h1, XFER_FAR_INTER = 2'h2,
    XFER_TASK = 2'h3
  } cfx_xfer_type;
  // Opcode bytes, kept for the decoder side
  localparam logic [7:0] OPC_BYTE_TO_WORD = 8'h98;
  localparam logic [7:0] OPC_DWORD_TO_QWORD = 8'h99;
  localparam logic [7:0] OPC_CLR_CARRY = 8'hf8;
  localparam logic [7:0] OPC_CLR_DIR = 8'hfc;
  localparam logic [7:0] OPC_CLR_INT = 8'hfa;
  localparam logic [15:0] OPC_CLR_TS = 16'h0f06;
  // Execution clocks per instruction
  localparam logic [3:0] CLK_BYTE_TO_WORD = 4'h3;
  localparam logic [3:0] CLK_DWORD_TO_QWORD = 4'h3;
  localparam logic [3:0] CLK_CLR_CARRY = 4'h2;
  localparam logic [3:0] CLK_CLR_DIR = 4'h2;
  localparam logic [3:0] CLK_CLR_INT = 4'h5;
  localparam logic [3:0] CLK_CLR_TS = 4'h7;
  // Fault vectors
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_PAGE = 8'h0e;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  // Masks and limits
  localparam logic [31:0] LOW_WORD_MASK = 32'h0000_ffff;
  localparam logic [32:0] REAL_EA_MAX = 33'h0_0000_ffff;
  localparam logic [31:0] SIGN_FILL = 32'hffff_ffff;
  // Flag bit positions and reset value
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_INT_EN = 9;
  localparam int FLAG_DIR = 10;
  localparam int FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  // Control register zero bit positions
  localparam int CR0_MP = 1;
  localparam int CR0_TS = 3;
  // Register port offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Access-rights byte fields
  localparam int AR_DPL_LO = 5;
  localparam int AR_SEG = 4;
  localparam int AR_CODE = 3;
  localparam int AR_CONF = 2;
  localparam logic [3:0] AR_TASK_GATE = 4'h5;
  localparam logic [3:0] AR_TSS_AVAIL = 4'h9;
  localparam logic [3:0] AR_CALL_GATE = 4'hc;
endpackage : cfx_pkg

// ==== test/call_and_flag_insn_exec_test.sv ====
// Self-checking bench for the call and flag executor.
// Assumes cfx_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none

module call_and_flag_insn_exec_test;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic issue_in = 1'b0, osz32_in = 1'b0, ind_mem_in = 1'b0;
  logic sp_base_in = 1'b0, ea_bad_in = 1'b0, stack_bad_in = 1'b0;
  logic page_fault_in = 1'b0, misaligned_in = 1'b0;
  logic esc_check_in = 1'b0, wait_check_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  cfx_pkg::cfx_op_type op_in = cfx_pkg::OP_NONE;
  cfx_pkg::cfx_mode_type mode_in = cfx_pkg::MODE_PROT;
  logic [1:0] current_privilege_level_in = 2'h0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] access_rights_byte_in = 8'h0, accum_low_byte_in = 8'h0;
  logic [15:0] far_sel_in = 16'h0, cur_cs_in = 16'h0;
  logic [31:0] next_ip_in = 32'h0, disp_in = 32'h0, ind_target_in = 32'h0;
  logic [31:0] far_off_in = 32'h0, cs_limit_in = 32'hffff_ffff;
  logic [31:0] stack_pointer_in = 32'h0, ea_base_in = 32'h0;
  logic [31:0] ea_disp_in = 32'h0, task_flags_in = 32'h0;
  logic [31:0] accum_dword_in = 32'h0, reg_wdata_in = 32'h0;
  logic done_out, fault_out, task_switched_bit_out, coproc_trap_out;
  logic [7:0] fault_vec_out, accum_high_byte_out;
  logic [15:0] cs_out, ret_cs_out;
  logic [31:0] instruction_pointer_out, ret_ip_out, data_dword_reg_out;
  logic [31:0] flags_out, reg_rdata_out, mem_ea_out;
  int error_cnt = 0;
  int n_tests = 0;

  cfx_exec u_cfx_exec (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .issue_in(issue_in),
    .op_in(op_in), .osz32_in(osz32_in), .mode_in(mode_in),
    .current_privilege_level_in(current_privilege_level_in),
    .next_ip_in(next_ip_in), .disp_in(disp_in),
    .ind_target_in(ind_target_in), .ind_mem_in(ind_mem_in),
    .far_sel_in(far_sel_in), .far_off_in(far_off_in),
    .access_rights_byte_in(access_rights_byte_in), .cur_cs_in(cur_cs_in),
    .cs_limit_in(cs_limit_in), .stack_pointer_in(stack_pointer_in),
    .sp_base_in(sp_base_in), .ea_base_in(ea_base_in),
    .ea_disp_in(ea_disp_in), .ea_bad_in(ea_bad_in),
    .stack_bad_in(stack_bad_in), .page_fault_in(page_fault_in),
    .misaligned_in(misaligned_in), .task_flags_in(task_flags_in),
    .accum_low_byte_in(accum_low_byte_in), .accum_dword_in(accum_dword_in),
    .esc_check_in(esc_check_in), .wait_check_in(wait_check_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .busy_out(),
    .done_out(done_out), .fault_out(fault_out),
    .fault_vec_out(fault_vec_out), .ip_wr_out(),
    .instruction_pointer_out(instruction_pointer_out), .cs_wr_out(),
    .cs_out(cs_out), .push_ip_out(), .push_cs_out(),
    .ret_ip_out(ret_ip_out), .ret_cs_out(ret_cs_out), .mem_ea_out(mem_ea_out),
    .xfer_out(), .task_switch_out(), .ah_wr_out(),
    .accum_high_byte_out(accum_high_byte_out), .edx_wr_out(),
    .data_dword_reg_out(data_dword_reg_out), .flags_out(flags_out),
    .task_switched_bit_out(task_switched_bit_out),
    .coproc_trap_out(coproc_trap_out), .reg_rdata_out(reg_rdata_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns period
  always #20 sys_clk_in = ~sys_clk_in;

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Issue one op, count edges to done and check the fault bit
  task automatic go(input cfx_pkg::cfx_op_type op, input int n,
                    input logic flt);
    int k;
    @(posedge sys_clk_in);
    issue_in <= 1'b1;
    op_in <= op;
    @(posedge sys_clk_in);
    issue_in <= 1'b0;
    k = 0;
    #1;
    while (done_out !== 1'b1 && k < 20) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    chk("cycles", 32'(k), 32'(n));
    chk("fault", {31'h0, fault_out}, {31'h0, flt});
  endtask : go

  // Register port write and read
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rdata", reg_rdata_out, e);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Flag clears and privilege refusal
  task automatic t_flags;
    wr(cfx_pkg::REG_FLAGS, 32'h0000_0603);
    go(cfx_pkg::OP_CLR_CARRY, 2, 1'b0);
    chk("flags", flags_out, 32'h0000_0602);
    go(cfx_pkg::OP_CLR_DIR, 2, 1'b0);
    chk("flags", flags_out, 32'h0000_0202);
    current_privilege_level_in <= 2'h3;
    go(cfx_pkg::OP_CLR_INT, 5, 1'b1);
    chk("vec", {24'h0, fault_vec_out}, 32'h0000_000d);
    chk("flags", flags_out, 32'h0000_0202);
    wr(cfx_pkg::REG_FLAGS, 32'h0000_3203);
    go(cfx_pkg::OP_CLR_INT, 5, 1'b0);
    chk("flags", flags_out, 32'h0000_3003);
    current_privilege_level_in <= 2'h0;
    rd(cfx_pkg::REG_FLAGS, 32'h0000_3003);
    rd(4'hc, 32'h0);
  endtask : t_flags

  // Sign extensions leave flags alone
  task automatic t_ext;
    accum_low_byte_in <= 8'h80;
    accum_dword_in <= 32'h8000_0000;
    go(cfx_pkg::OP_BYTE_TO_WORD, 3, 1'b0);
    chk("ah", {24'h0, accum_high_byte_out}, 32'h0000_00ff);
    go(cfx_pkg::OP_DWORD_TO_QWORD, 3, 1'b0);
    chk("edx", data_dword_reg_out, 32'hffff_ffff);
    accum_low_byte_in <= 8'h7f;
    go(cfx_pkg::OP_BYTE_TO_WORD, 3, 1'b0);
    chk("ah", {24'h0, accum_high_byte_out}, 32'h0);
    chk("flags", flags_out, 32'h0000_3003);
  endtask : t_ext

  // Near calls in protected mode
  task automatic t_near;
    next_ip_in <= 32'h0001_fff0;
    disp_in <= 32'h0000_0020;
    go(cfx_pkg::OP_CALL_REL, 3, 1'b0);
    chk("ip", instruction_pointer_out, 32'h0000_0010);
    chk("ret_ip", ret_ip_out, 32'h0000_fff0);
    osz32_in <= 1'b1;
    next_ip_in <= 32'h1234_0000;
    disp_in <= 32'hffff_fff0;
    go(cfx_pkg::OP_CALL_REL, 3, 1'b0);
    chk("ip", instruction_pointer_out, 32'h1233_fff0);
    chk("ret_ip", ret_ip_out, 32'h1234_0000);
    osz32_in <= 1'b0;
    ind_target_in <= 32'habcd_1234;
    go(cfx_pkg::OP_CALL_IND, 3, 1'b0);
    chk("ip", instruction_pointer_out, 32'h0000_1234);
    chk("flags", flags_out, 32'h0000_3003);
    page_fault_in <= 1'b1;
    go(cfx_pkg::OP_CALL_IND, 3, 1'b1);
    chk("vec", {24'h0, fault_vec_out}, 32'h0000_000e);
    page_fault_in <= 1'b0;
  endtask : t_near

  // Far call through memory in real mode
  task automatic t_far;
    mode_in <= cfx_pkg::MODE_REAL;
    far_sel_in <= 16'h1234;
    far_off_in <= 32'h0000_5678;
    cur_cs_in <= 16'h0f00;
    next_ip_in <= 32'h0000_0100;
    sp_base_in <= 1'b1;
    stack_pointer_in <= 32'h0000_0010;
    go(cfx_pkg::OP_CALL_FAR_IND, 3, 1'b0);
    chk("cs", {16'h0, cs_out}, 32'h0000_1234);
    chk("ip", instruction_pointer_out, 32'h0000_5678);
    chk("ret_cs", {16'h0, ret_cs_out}, 32'h0000_0f00);
    chk("ret_ip", ret_ip_out, 32'h0000_0100);
    chk("ea", mem_ea_out, 32'h0000_0010);
    sp_base_in <= 1'b0;
    ea_base_in <= 32'h0000_fffe;
    go(cfx_pkg::OP_CALL_FAR_IND, 3, 1'b1);
    chk("vec", {24'h0, fault_vec_out}, 32'h0000_000d);
    mode_in <= cfx_pkg::MODE_PROT;
    // Far call to an available task segment switches tasks
    access_rights_byte_in <= 8'h09;
    task_flags_in <= 32'h0000_0001;
    go(cfx_pkg::OP_CALL_FAR_DIR, 3, 1'b0);
    chk("flags", flags_out, 32'h0000_0003);
    chk("ts", {31'h0, task_switched_bit_out}, 32'h1);
  endtask : t_far

  // Task-switched bit, escape trap and its clear
  task automatic t_ts;
    wr(cfx_pkg::REG_CTRL, 32'h0000_0008);
    chk("ts", {31'h0, task_switched_bit_out}, 32'h1);
    @(posedge sys_clk_in);
    esc_check_in <= 1'b1;
    @(posedge sys_clk_in);
    esc_check_in <= 1'b0;
    #1;
    chk("trap", {31'h0, coproc_trap_out}, 32'h1);
    current_privilege_level_in <= 2'h1;
    go(cfx_pkg::OP_CLR_TS, 7, 1'b1);
    chk("ts", {31'h0, task_switched_bit_out}, 32'h1);
    current_privilege_level_in <= 2'h0;
    go(cfx_pkg::OP_CLR_TS, 7, 1'b0);
    chk("ts", {31'h0, task_switched_bit_out}, 32'h0);
  endtask : t_ts

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // Main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    #1;
    chk("flags_rst", flags_out, 32'h0000_0002);
    t_flags;
    t_ext;
    t_near;
    t_far;
    t_ts;
    print_verdict;
  end

  // Watchdog well past the expected run length
  initial begin
    #(40 * 4000);
    error_cnt++;
    print_verdict;
  end
endmodule : call_and_flag_insn_exec_test

`default_nettype wire
